// [src/sep_slave.v]
// Two-wire serial EEPROM slave: bus front end, page buffer, programming.
// Assumes scl, sda_in, straps and write protect come from pins.
`include "sep_defs.vh"
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R1] Sample on SCL rise, drive after fall
// [R2] Data line only pulled low or released
// [R3] Three straps give static device identity
// [R4] Write protect high blocks all array changes
// [R5] 2048 bytes, 128 pages of 16 bytes
// [R6] Master keeps SCL at or below limit
// [R7] Slave only, never drives SCL
// [R8] Standby after STOP or programming end
// [R9] START is SDA fall while SCL high
// [R10] STOP is SDA rise while SCL high
// [R11] STOP after write data starts programming
// [R12] Receiver acks ninth clock, sender releases
// [R13] Acknowledge each accepted received byte
// [R14] Nine clocks per byte, MSB first
// [R15] Command byte then one control byte
// [R16] Match bit 7 and straps, middle inverted
// [R17] Bit 0 selects write or read
// [R18] Write command bits 3..1 give top address
// [R19] Byte after write command loads low address
// [R20] Keep sending while master acknowledges
// [R21] Counter advances after each data byte
// [R22] Page entry wraps in four low bits
// [R23] No command ack while programming
// [R24] Mismatch: release line, wait for START
module sep_slave #(
   parameter PROG_CYCLES = `SEP_PROG_CYCLES,
   parameter AW = `SEP_ADDR_W,
   parameter PAGE = `SEP_PAGE_BYTES
) (
   input wire sys_clk,
   input wire srst,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   input wire select_strap_0,
   input wire select_strap_1,
   input wire select_strap_2,
   input wire write_protect,
   output wire busy,
   output wire standby
);
   // ****************************************
   // States
   // ****************************************
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_CMD = 3'h1;
   localparam [2:0] ST_ADDR = 3'h2;
   localparam [2:0] ST_WDATA = 3'h3;
   localparam [2:0] ST_RDATA = 3'h4;
   localparam [2:0] ST_RACK = 3'h5;
   localparam [2:0] ST_PROG = 3'h6;
   localparam [2:0] ST_PGW = 3'h7;
   localparam PLW = `SEP_PAGE_LSB_W;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   wire scl_lvl, scl_rise, scl_fall;
   wire sda_lvl, sda_rise, sda_fall;
   reg wp_meta_reg;
   reg wp_sync_reg;
   reg [2:0] strap_meta_reg;
   reg [2:0] strap_sync_reg;
   sep_sync u_scl (
      .sys_clk(sys_clk),
      .srst(srst),
      .pin_in(scl_in),
      .level(scl_lvl),
      .rise(scl_rise),
      .fall(scl_fall)
   );
   sep_sync u_sda (
      .sys_clk(sys_clk),
      .srst(srst),
      .pin_in(sda_in),
      .level(sda_lvl),
      .rise(sda_rise),
      .fall(sda_fall)
   );
   // Straps are static but may be driven by logic; sync them anyway [R3]
   always @(posedge sys_clk) begin
      if (srst) begin
         strap_meta_reg <= 3'h0;
         strap_sync_reg <= 3'h0;
      end else begin
         strap_meta_reg <= {select_strap_2, select_strap_1, select_strap_0};
         strap_sync_reg <= strap_meta_reg;
      end
   end

   // Write protect resets to protected so no early STOP programs [R4]
   always @(posedge sys_clk) begin
      if (srst) begin
         wp_meta_reg <= 1'b1;
         wp_sync_reg <= 1'b1;
      end else begin
         wp_meta_reg <= write_protect;
         wp_sync_reg <= wp_meta_reg;
      end
   end

   // ****************************************
   // Bus conditions
   // ****************************************
   wire start_det = sda_fall & scl_lvl; // [R9]
   wire stop_det = sda_rise & scl_lvl; // [R10]
   wire wp_lvl = wp_sync_reg;

   function sel_match;
      input [7:0] cmd;
      input [2:0] straps;
      begin
         sel_match = cmd[`SEP_CMD_FIXED_BIT] &
            (cmd[6] == straps[2]) & (cmd[5] == ~straps[1]) &
            (cmd[4] == straps[0]);
      end
   endfunction

   // Programming states ignore the bus entirely
   function in_prog;
      input [2:0] st;
      begin
         in_prog = (st == ST_PROG) | (st == ST_PGW);
      end
   endfunction

   // Pull-low request for one outgoing bit, MSB first
   function out_bit_low;
      input [7:0] data;
      input [2:0] idx;
      begin
         out_bit_low = ~data[3'h7 - idx];
      end
   endfunction

   // Next write address: only the in-page bits advance
   function [AW-1:0] page_step;
      input [AW-1:0] addr;
      begin
         page_step = {addr[AW-1:PLW], addr[PLW-1:0] + 1'b1};
      end
   endfunction

   // ****************************************
   // Registers
   // ****************************************
   reg [2:0] state_reg;
   reg [3:0] bit_reg;
   reg [7:0] shift_reg;
   reg ack_phase_reg;
   reg ack_drive_reg;
   reg out_low_reg;
   reg [AW-1:0] addr_reg;
   reg [AW-1:0] page_reg;
   reg [7:0] pbuf [0:PAGE-1];
   reg [PAGE-1:0] pmark_reg;
   reg [PLW-1:0] pidx_reg;
   reg [31:0] prog_cnt_reg;
   reg have_data_reg;
   reg mem_wr_reg;
   reg [7:0] mem_wd_reg;
   reg [AW-1:0] mem_wa_reg;
   wire [7:0] mem_rd;

   sep_mem #(.AW(AW), .DEPTH(`SEP_MEM_BYTES)) u_mem ( // [R5]
      .sys_clk(sys_clk),
      .wr_en(mem_wr_reg),
      .wr_addr(mem_wa_reg),
      .wr_data(mem_wd_reg),
      .rd_addr(addr_reg),
      .rd_data(mem_rd)
   );

   wire [7:0] shifted = {shift_reg[6:0], sda_lvl};

   // ****************************************
   // Bus engine
   // ****************************************
   always @(posedge sys_clk) begin
      mem_wr_reg <= 1'b0;
      if (srst) begin
         state_reg <= ST_IDLE;
         bit_reg <= 4'h0;
         shift_reg <= 8'h00;
         ack_phase_reg <= 1'b0;
         ack_drive_reg <= 1'b0;
         out_low_reg <= 1'b0;
         addr_reg <= {AW{1'b0}};
         page_reg <= {AW{1'b0}};
         pmark_reg <= {PAGE{1'b0}};
         pidx_reg <= {PLW{1'b0}};
         prog_cnt_reg <= 32'h0;
         have_data_reg <= 1'b0;
         mem_wd_reg <= 8'h00;
         mem_wa_reg <= {AW{1'b0}};
      end else if (in_prog(state_reg)) begin
         // Programming ignores the bus; commands get no ack [R23]
         ack_drive_reg <= 1'b0;
         out_low_reg <= 1'b0;
         if (state_reg == ST_PROG) begin
            if (pmark_reg[pidx_reg]) begin
               mem_wr_reg <= 1'b1;
               mem_wa_reg <= {page_reg[AW-1:PLW], pidx_reg};
               mem_wd_reg <= pbuf[pidx_reg];
            end
            pidx_reg <= pidx_reg + 1'b1;
            if (pidx_reg == {PLW{1'b1}}) begin
               state_reg <= ST_PGW;
               prog_cnt_reg <= 32'h0;
            end
         end else if (prog_cnt_reg >= PROG_CYCLES - 1) begin
            state_reg <= ST_IDLE; // [R8]
            pmark_reg <= {PAGE{1'b0}};
         end else begin
            prog_cnt_reg <= prog_cnt_reg + 32'h1;
         end
      end else if (stop_det) begin
         // A STOP ends any transfer, even in mid-byte [R10]
         ack_drive_reg <= 1'b0;
         out_low_reg <= 1'b0;
         if (state_reg == ST_WDATA && have_data_reg && !wp_lvl) begin
            state_reg <= ST_PROG; // [R11] [R4]
            pidx_reg <= {PLW{1'b0}};
         end else begin
            state_reg <= ST_IDLE; // [R8] [R11]
            pmark_reg <= {PAGE{1'b0}};
         end
      end else if (start_det) begin
         // Also taken as a repeated start in mid-transfer [R9]
         state_reg <= ST_CMD; // [R15]
         bit_reg <= 4'h0;
         ack_phase_reg <= 1'b0;
         ack_drive_reg <= 1'b0;
         out_low_reg <= 1'b0;
         have_data_reg <= 1'b0;
         pmark_reg <= {PAGE{1'b0}};
      end else if (scl_rise && state_reg != ST_IDLE) begin
         // Inputs are taken on the bus clock rise [R1]
         if (ack_phase_reg) begin
            // Ninth clock: acknowledge slot [R12] [R14]
            if (state_reg == ST_RACK) begin
               if (sda_lvl) begin
                  state_reg <= ST_IDLE; // [R20]
               end else begin
                  state_reg <= ST_RDATA; // [R20]
               end
            end
         end else if (state_reg != ST_RDATA) begin
            shift_reg <= shifted; // [R1] [R14]
            bit_reg <= bit_reg + 4'h1;
         end else begin
            bit_reg <= bit_reg + 4'h1;
         end
      end else if (scl_fall && state_reg != ST_IDLE) begin
         // Outputs change only just after the bus clock fall [R1]
         if (ack_phase_reg) begin
            ack_phase_reg <= 1'b0;
            ack_drive_reg <= 1'b0;
            bit_reg <= 4'h0;
            out_low_reg <= 1'b0;
            if (state_reg == ST_RDATA) begin
               out_low_reg <= out_bit_low(mem_rd, 3'h0); // [R1]
               shift_reg <= mem_rd;
            end
         end else if (bit_reg == 4'h8) begin
            ack_phase_reg <= 1'b1;
            out_low_reg <= 1'b0; // [R12]
            case (state_reg)
               ST_CMD: begin
                  if (sel_match(shift_reg, strap_sync_reg[2:0])) begin
                     ack_drive_reg <= 1'b1; // [R16] [R3] [R13]
                     if (shift_reg[`SEP_CMD_DIR_BIT]) begin
                        state_reg <= ST_RDATA; // [R17] [R18]
                     end else begin
                        state_reg <= ST_ADDR; // [R17]
                        addr_reg[AW-1:8] <= shift_reg[3:1]; // [R18]
                     end
                  end else begin
                     state_reg <= ST_IDLE; // [R24]
                  end
               end
               ST_ADDR: begin
                  ack_drive_reg <= 1'b1; // [R13]
                  addr_reg[7:0] <= shift_reg; // [R19]
                  page_reg[7:0] <= shift_reg;
                  page_reg[AW-1:8] <= addr_reg[AW-1:8];
                  state_reg <= ST_WDATA;
               end
               ST_WDATA: begin
                  ack_drive_reg <= 1'b1; // [R13]
                  pbuf[addr_reg[PLW-1:0]] <= shift_reg;
                  pmark_reg[addr_reg[PLW-1:0]] <= 1'b1;
                  have_data_reg <= 1'b1;
                  addr_reg <= page_step(addr_reg); // [R21] [R22]
               end
               ST_RDATA: begin
                  addr_reg <= addr_reg + 1'b1; // [R21]
                  state_reg <= ST_RACK;
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end else if (state_reg == ST_RDATA) begin
            if (bit_reg != 4'h0) begin
               out_low_reg <= out_bit_low(shift_reg, bit_reg[2:0]); // [R14]
            end
         end
      end else if (state_reg == ST_RDATA && ack_phase_reg == 1'b0 &&
                   bit_reg == 4'h0 && !scl_lvl && !out_low_reg &&
                   !mem_rd[7] && shift_reg != mem_rd) begin
         // First bit after the command or data ack: memory word now valid
         shift_reg <= mem_rd;
         out_low_reg <= 1'b1;
      end else if (state_reg == ST_RDATA && ack_phase_reg == 1'b0 &&
                   bit_reg == 4'h0 && !scl_lvl) begin
         // Keep the first read bit on the line until the next clock rise
         shift_reg <= mem_rd;
         out_low_reg <= out_bit_low(mem_rd, 3'h0);
      end
   end

   // ****************************************
   // Pin drive: open drain, pull low only
   // ****************************************
   assign sda_out = 1'b0; // [R2]
   assign sda_oe = ack_drive_reg | out_low_reg; // [R2] [R7]

   // Status levels for the surrounding logic
   assign busy = in_prog(state_reg);
   assign standby = (state_reg == ST_IDLE);
endmodule // sep_slave
`default_nettype wire

// [src/sep_defs.vh]
// Constants for the two-wire EEPROM slave front end.
// Assumes inclusion by bare name from src/.
`ifndef SEP_DEFS_VH
`define SEP_DEFS_VH

`define SEP_MEM_BYTES 2048
`define SEP_ADDR_W 11
`define SEP_PAGE_BYTES 16
`define SEP_PAGE_LSB_W 4
`define SEP_CMD_FIXED_BIT 7
`define SEP_CMD_SEL_HI 6
`define SEP_CMD_SEL_LO 4
`define SEP_CMD_ADDR_HI 3
`define SEP_CMD_ADDR_LO 1
`define SEP_CMD_DIR_BIT 0
`define SEP_ERASED_BYTE 8'hFF
`define SEP_PROG_TIME_US 8000
`define SEP_CLK_MHZ 200
`define SEP_PROG_CYCLES (`SEP_PROG_TIME_US * `SEP_CLK_MHZ)

`endif

// [src/sep_sync.v]
// Two-flop synchroniser with edge and level outputs for one pin.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module sep_sync (
   input wire sys_clk,
   input wire srst,
   input wire pin_in,
   output wire level,
   output wire rise,
   output wire fall
);
   reg meta_reg;
   reg sync_reg;
   reg last_reg;
   always @(posedge sys_clk) begin
      if (srst) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         last_reg <= 1'b1;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end
   assign level = sync_reg;
   assign rise = sync_reg & ~last_reg;
   assign fall = ~sync_reg & last_reg;
endmodule // sep_sync
`default_nettype wire

// [src/sep_mem.v]
// Byte array of the EEPROM with one read and one write port.
// Assumes the caller serialises writes.
`timescale 1ns/1ps
`default_nettype none
module sep_mem #(
   parameter AW = 11,
   parameter DEPTH = 2048
) (
   input wire sys_clk,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [7:0] wr_data,
   input wire [AW-1:0] rd_addr,
   output reg [7:0] rd_data
);
   reg [7:0] mem [0:DEPTH-1];
   always @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // sep_mem
`default_nettype wire

// [verification/sep_slave_monitor.sv]
// Checker for the two-wire EEPROM slave, bound to its top module.
// Assumes the bus pins are settled on sys_clk edges.
`timescale 1ns/1ps
`default_nettype none
module sep_slave_monitor #(
   parameter PROG_CYCLES = 50
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic write_protect,
   input wire logic busy,
   input wire logic standby
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic [31:0] busy_cnt;
   always_ff @(posedge sys_clk) begin
      busy_cnt <= (srst || !busy) ? 32'h0 : busy_cnt + 32'h1;
   end
   // ***********************************
   // Properties
   // ***********************************
   a_out_open_drain: assert property (sda_out == 1'b0)
      else $error("data pin output drives high");
   a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("data pulled low while bus clock high");
   a_oe_stable_high: assert property
      (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("data changed while bus clock high");
   a_busy_no_ack: assert property (busy |-> !sda_oe)
      else $error("bus answered while programming");
   a_busy_not_idle: assert property (busy |-> !standby)
      else $error("standby while programming");
   a_idle_released: assert property (standby |-> !sda_oe)
      else $error("data held low in standby");
   a_stop_ends: assert property
      (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:8] (standby || busy))
      else $error("stop did not end the transfer");
   a_busy_length: assert property ($fell(busy) |->
      busy_cnt >= PROG_CYCLES && busy_cnt <= PROG_CYCLES + 16)
      else $error("programming time wrong");
   a_wp_blocks: assert property
      (scl_in && $rose(sda_in) && write_protect && !busy |=> !busy [*8])
      else $error("programming while write protected");
endmodule // sep_slave_monitor
bind sep_slave sep_slave_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon_i (
   .sys_clk(sys_clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
   .busy(busy), .standby(standby));
`default_nettype wire

// [verification/sep_master.sv]
// Bus master model: clock of 25 sys_clk cycles, open-drain data.
// Assumes the bench resolves the wire from sda_low and the slave.
`timescale 1ns/1ps
`default_nettype none
module sep_master (
   input wire logic sys_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Bus period is fixed by the bench, scaled far above the real rate
   // Data set mid low phase, sampled mid high phase
   task automatic bit_io(input logic b, output logic r);
      tick(6);
      sda_low <= ~b;
      tick(7);
      scl <= 1'b1;
      tick(6);
      r = sda;
      tick(6);
      scl <= 1'b0;
   endtask
   task automatic start();
      tick(6);
      sda_low <= 1'b0;
      tick(7);
      scl <= 1'b1;
      tick(6);
      sda_low <= 1'b1;
      tick(6);
      scl <= 1'b0;
   endtask
   task automatic stop();
      tick(6);
      sda_low <= 1'b1;
      tick(7);
      scl <= 1'b1;
      tick(6);
      sda_low <= 1'b0;
      tick(6);
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic recv(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(~ack, r);
   endtask
endmodule // sep_master
`default_nettype wire

// [verification/sep_slave_tb.sv]
// Self-checking bench for the EEPROM slave with a bus master model.
// Assumes a pull-up on the data wire.
`timescale 1ns/1ps
`default_nettype none
module sep_slave_tb;
   localparam int PROG = 2000;
   localparam logic [10:0] BASE = 11'h5A0;
   logic sys_clk, srst, wp, ack;
   logic [2:0] strap;
   logic [7:0] d;
   wire scl, sda, m_low, sda_out, sda_oe, busy, standby;
   int errors, tests_run;
   assign sda = ~sda_oe & ~m_low;
   sep_slave #(.PROG_CYCLES(PROG)) sep_slave_i (.sys_clk(sys_clk),
      .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .select_strap_0(strap[0]), .select_strap_1(strap[1]),
      .select_strap_2(strap[2]), .write_protect(wp), .busy(busy),
      .standby(standby));
   sep_master sep_master_i (.sys_clk(sys_clk), .sda(sda), .scl(scl),
      .sda_low(m_low));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   function automatic logic [7:0] pat(input logic [10:0] a);
      return a[7:0] ^ 8'h3C;
   endfunction
   function automatic logic [7:0] cmd(input logic [2:0] s, hi, input logic rd);
      return {1'b1, s[2], ~s[1], s[0], hi, rd};
   endfunction
   task automatic check(input logic [7:0] got, exp, input string what);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic wr_cmd(input logic [7:0] c, input logic exp_ack);
      sep_master_i.start();
      sep_master_i.send(c, ack);
      check({7'h00, ack}, {7'h00, exp_ack}, "command ack");
   endtask
   task automatic set_addr(input logic [10:0] a);
      wr_cmd(cmd(strap, a[10:8], 1'b0), 1'b1);
      sep_master_i.send(a[7:0], ack);
      check({7'h00, ack}, 8'h01, "address ack");
   endtask
   task automatic rd(input logic [10:0] a, input int n);
      set_addr(a);
      wr_cmd(cmd(strap, 3'b010, 1'b1), 1'b1);
      for (int k = 0; k < n; k++) begin
         sep_master_i.recv(k < n - 1, d);
         check(d, pat(a + 11'(k)), "read data");
      end
      sep_master_i.stop();
   endtask
   task automatic wait_idle();
      for (int i = 0; i < PROG + 200 && busy !== 1'b0; i++) @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
      check({7'h00, standby}, 8'h01, "standby");
   endtask
   task automatic print_verdict();
      $display("tests %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk);
      errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      print_verdict();
   end
   initial begin
      errors = 0;
      tests_run = 0;
      srst = 1'b1;
      wp = 1'b0;
      strap = 3'b101;
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (8) @(posedge sys_clk);
      set_addr(BASE + 11'd15);
      for (int k = 0; k < 4; k++) begin
         sep_master_i.send(pat(BASE + 11'((15 + k) % 16)), ack);
         check({7'h00, ack}, 8'h01, "data ack");
      end
      sep_master_i.stop();
      repeat (10) @(posedge sys_clk);
      check({7'h00, busy}, 8'h01, "programming");
      wr_cmd(cmd(strap, BASE[10:8], 1'b0), 1'b0);
      sep_master_i.stop();
      wait_idle();
      $display("test page_write done");
      rd(BASE, 3);
      rd(BASE + 11'd15, 1);
      $display("test read done");
      for (int s = 0; s < 8; s++) begin
         @(posedge sys_clk) strap <= 3'(s);
         wr_cmd(cmd(3'(s), 3'b000, 1'b0), 1'b1);
         sep_master_i.stop();
         wr_cmd(cmd(3'(s), 3'b000, 1'b0) ^ 8'h20, 1'b0);
         wr_cmd(cmd(3'(s), 3'b000, 1'b0) & 8'h7F, 1'b0);
         sep_master_i.stop();
      end
      @(posedge sys_clk) strap <= 3'b101;
      $display("test straps done");
      @(posedge sys_clk) wp <= 1'b1;
      set_addr(BASE + 11'd15);
      sep_master_i.send(~pat(BASE + 11'd15), ack);
      sep_master_i.stop();
      wait_idle();
      @(posedge sys_clk) wp <= 1'b0;
      rd(BASE + 11'd15, 1);
      $display("test write_protect done");
      print_verdict();
   end
endmodule // sep_slave_tb
`default_nettype wire
